// ---- hdl/rspi_slave.sv ----
// Overview of operation
// - one 32-bit frame per select, MSB first, device is slave only
// - reply: address echo, 16 data, 2-bit status, CRC-6
// - reply to a frame is sent during the next frame
// - angle or velocity read loads reply within two cycles
// - echo holds previous frame address; address picks register, except that angle and velocity reads both return the vel_select_i choice
// - data field is 16 bits, MSB first, both directions
// - status 0 ok, 1 crc/clock, 2 output mismatch, 3 address
// - crc error beats mismatch beats address error
// - reading status one clears spi error; read status four first
// - CRC-6 over upper 24 bits, poly x6+x4+x3+x+1, seed ones
// - CRC computed serially from the most significant bit
// - 000F,0055,00AA,00F0 to device unlock opens control registers
// - same sequence to eeprom unlock opens eeprom control
// - unlock sequence must finish within 10 ms of first write
// - parity is xor of twelve data bits and sign term
// - sign term 0 for angle and positive velocity, else 1
// - parity on pin and in angle and velocity registers
// - actual output pin levels sampled as monitor flags
// - only alarm pin mismatch raises output fault
// - diagnostics-only write in normal state gets status 3
`timescale 1ns/1ns
`default_nettype none
module rspi_slave #(
  parameter int unsigned UNLOCK_CYC = rspi_pkg::UNLOCK_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // spi pins
  input  wire logic        chip_select_n_i,
  input  wire logic        sclk_i,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  // core data
  input  wire logic [11:0] angle_i,
  input  wire logic [11:0] velocity_i,
  input  wire logic        velocity_neg_i,
  input  wire logic        vel_select_i,
  input  wire logic        diag_state_i,
  // driven output values
  input  wire logic        encoder_channel_a_out_i,
  input  wire logic        encoder_channel_b_out_i,
  input  wire logic        encoder_index_out_i,
  input  wire logic        alarm_drive_i,
  // pad readback levels
  input  wire logic        pad_a_i,
  input  wire logic        pad_b_i,
  input  wire logic        pad_z_i,
  input  wire logic        pad_alarm_i,
  input  wire logic [11:0] pad_ord_i,
  input  wire logic        pad_prd_i,
  // parallel output
  output logic [11:0]      angle_velocity_out_bits_o,
  output logic             output_parity_bit_o,
  // status and control
  output logic             output_pin_mismatch_error_o,
  output logic [15:0]      protected_control_one_o,
  output logic [15:0]      protected_control_two_o,
  output logic [15:0]      eeprom_control_register_o,
  output logic [15:0]      diag_config_o,
  output logic             ctrl_unlocked_o,
  output logic             ee_unlocked_o
);
  function automatic logic [5:0] crc_step(input logic [5:0] c, input logic b);
    logic inv;
    inv = c[5] ^ b;
    crc_step = {c[4], c[3] ^ inv, c[2] ^ inv, c[1], c[0] ^ inv, inv};
  endfunction

  function automatic logic parity12(input logic [11:0] d, input logic s);
    parity12 = s ^ (^d);
  endfunction

  // pin synchronisers
  logic [1:0] cs_s_r, sck_s_r, sdi_s_r, cs_s_nxt, sck_s_nxt, sdi_s_nxt;
  logic [5:0] pads_s1_r, pads_s2_r, pads_s1_nxt, pads_s2_nxt;
  logic [12:0] ordp_s1_r, ordp_s2_r, ordp_s1_nxt, ordp_s2_nxt;
  logic        sck_d_r, sck_d_nxt;

  always_comb
  begin
    cs_s_nxt    = {cs_s_r[0], chip_select_n_i};
    sck_s_nxt   = {sck_s_r[0], sclk_i};
    sdi_s_nxt   = {sdi_s_r[0], sdi_i};
    sck_d_nxt   = sck_s_r[1];
    pads_s1_nxt = {pad_a_i, pad_b_i, pad_z_i, pad_alarm_i, 2'h0};
    pads_s2_nxt = pads_s1_r;
    ordp_s1_nxt = {pad_prd_i, pad_ord_i};
    ordp_s2_nxt = ordp_s1_r;
  end

  logic cs_n, rise, fall;
  assign cs_n = cs_s_r[1];
  assign rise = sck_s_r[1] & ~sck_d_r;
  assign fall = ~sck_s_r[1] & sck_d_r;

  // frame engine state
  logic [31:0] rx_r, rx_nxt;
  logic [31:0] tx_r, tx_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [5:0]  crc_r, crc_nxt;
  logic        busy_r, busy_nxt;
  logic        sdo_r, sdo_nxt;
  logic        oe_r, oe_nxt;
  logic [7:0]  echo_r, echo_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [1:0]  stat_r, stat_nxt;
  logic        spierr_r, spierr_nxt;
  logic [15:0] ctl1_r, ctl1_nxt, ctl2_r, ctl2_nxt, eectl_r, eectl_nxt;
  logic [15:0] dcfg_r, dcfg_nxt;
  logic        load_r, load_nxt;
  logic [11:0] ord_r, ord_nxt;
  logic        prd_r, prd_nxt;
  logic        iof_r, iof_nxt;
  logic        dmis_r, dmis_nxt;

  // monitor flags, wired from second sync stage
  logic [3:0]  enc_mon;
  logic        ord_mon, prd_mon;
  assign enc_mon = pads_s2_r[5:2];
  assign ord_mon = (ordp_s2_r[11:0] == ord_r);
  assign prd_mon = (ordp_s2_r[12] == prd_r);

  logic unlk_wr, eeunlk_wr, ctrl_open, ee_open;

  // frame end decode
  logic [7:0]  fa;
  logic [15:0] fd;
  logic        crc_ok, clk_ok, end_evt;
  assign fa      = rx_r[31:24];
  assign fd      = rx_r[23:8];
  assign crc_ok  = (rx_r[5:0] == crc_r);
  assign clk_ok  = (cnt_r == 6'h20);
  assign end_evt = busy_r & cs_n;
  assign unlk_wr   = end_evt & crc_ok & clk_ok & (fa == rspi_pkg::WR_UNLK);
  assign eeunlk_wr = end_evt & crc_ok & clk_ok & (fa == rspi_pkg::WR_EEUNLK);

  rspi_unlock #(.WINDOW_CYC(UNLOCK_CYC)) u_dev_unlock (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .wr_i       (unlk_wr),
    .data_i     (fd),
    .unlocked_o (ctrl_open)
  );

  rspi_unlock #(.WINDOW_CYC(UNLOCK_CYC)) u_ee_unlock (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .wr_i       (eeunlk_wr),
    .data_i     (fd),
    .unlocked_o (ee_open)
  );

  logic [5:0] resp_crc;
  always_comb
  begin
    resp_crc = rspi_pkg::CRC_SEED;
    for (int i = 23; i >= 0; i--)
    begin
      resp_crc = crc_step(resp_crc, tx_r[i + 8]);
    end
  end

  logic [1:0]  st;
  logic [15:0] rd;
  logic        addr_bad, wr_hit;

  always_comb
  begin
    rx_nxt     = rx_r;
    tx_nxt     = tx_r;
    cnt_nxt    = cnt_r;
    crc_nxt    = crc_r;
    busy_nxt   = busy_r;
    sdo_nxt    = sdo_r;
    oe_nxt     = ~cs_n;
    echo_nxt   = echo_r;
    rdata_nxt  = rdata_r;
    stat_nxt   = stat_r;
    spierr_nxt = spierr_r;
    ctl1_nxt   = ctl1_r;
    ctl2_nxt   = ctl2_r;
    eectl_nxt  = eectl_r;
    dcfg_nxt   = dcfg_r;
    load_nxt   = 1'b0;
    st         = rspi_pkg::ST_OK;
    rd         = 16'h0000;
    addr_bad   = 1'b0;
    wr_hit     = 1'b0;
    if (!cs_n && !busy_r)
    begin
      busy_nxt = 1'b1;
      cnt_nxt  = 6'h00;
      crc_nxt  = rspi_pkg::CRC_SEED;
      sdo_nxt  = tx_r[31];
    end
    else if (busy_r && !cs_n)
    begin
      if (rise)
      begin
        rx_nxt  = {rx_r[30:0], sdi_s_r[1]};
        cnt_nxt = (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;
        if (cnt_r < 6'h18)
        begin
          crc_nxt = crc_step(crc_r, sdi_s_r[1]);
        end
      end
      if (fall)
      begin
        tx_nxt  = {tx_r[30:0], 1'b0};
        sdo_nxt = tx_r[30];
      end
    end
    else if (end_evt)
    begin
      busy_nxt = 1'b0;
      echo_nxt = fa;
      unique case (fa)
        rspi_pkg::RD_CTRL1:   rd = ctl1_r;
        rspi_pkg::RD_CTRL2:   rd = ctl2_r;
        rspi_pkg::RD_EECTL:   rd = eectl_r;
        rspi_pkg::RD_DIAGCFG: rd = dcfg_r;
        rspi_pkg::RD_UNLK,
        rspi_pkg::RD_EEUNLK:  rd = 16'h0000;
        rspi_pkg::RD_STAT1:   rd = {15'h0000, spierr_r};
        rspi_pkg::RD_STAT2:   rd = {14'h0000, ord_mon, prd_mon};
        rspi_pkg::RD_STAT4:   rd = {10'h000, enc_mon, iof_r, spierr_r};
        rspi_pkg::RD_STAT5,
        rspi_pkg::RD_STAT6:   load_nxt = 1'b1;
        rspi_pkg::WR_CTRL1:   begin wr_hit = ctrl_open; addr_bad = ~ctrl_open; end
        rspi_pkg::WR_CTRL2:   begin wr_hit = ctrl_open; addr_bad = ~ctrl_open; end
        rspi_pkg::WR_EECTL:   begin wr_hit = ee_open; addr_bad = ~ee_open; end
        rspi_pkg::WR_DIAGCFG: begin wr_hit = diag_state_i; addr_bad = ~diag_state_i; end
        rspi_pkg::WR_UNLK,
        rspi_pkg::WR_EEUNLK:  wr_hit = 1'b0;
        default:              addr_bad = 1'b1;
      endcase
      if (!crc_ok || !clk_ok || rx_r[7:6] != 2'h0)
      begin
        st = rspi_pkg::ST_CRC;
      end
      else if (dmis_r)
      begin
        st = rspi_pkg::ST_MISMATCH;
      end
      else if (addr_bad)
      begin
        st = rspi_pkg::ST_ADDR;
      end
      if (st == rspi_pkg::ST_OK && wr_hit)
      begin
        if (fa == rspi_pkg::WR_CTRL1) ctl1_nxt = fd;
        if (fa == rspi_pkg::WR_CTRL2) ctl2_nxt = fd;
        if (fa == rspi_pkg::WR_EECTL) eectl_nxt = fd;
        if (fa == rspi_pkg::WR_DIAGCFG) dcfg_nxt = fd;
      end
      stat_nxt  = st;
      rdata_nxt = rd;
      if (fa == rspi_pkg::RD_STAT1 && st != rspi_pkg::ST_CRC)
      begin
        spierr_nxt = 1'b0;
      end
      if (st == rspi_pkg::ST_CRC)
      begin
        spierr_nxt = 1'b1; // set wins over clear
      end
      tx_nxt = {fa, rd, st, 6'h00};
    end
    else if (load_r)
    begin
      rdata_nxt = {2'h0, vel_select_i & velocity_neg_i, prd_r, ord_r};
      tx_nxt    = {tx_r[31:24], rdata_nxt, tx_r[7:0]};
    end
    else if (cs_n)
    begin
      tx_nxt[5:0] = resp_crc;
    end
  end

  // parallel output and pin monitor
  logic [3:0] drv_now;
  always_comb
  begin
    ord_nxt  = vel_select_i ? velocity_i : angle_i;
    prd_nxt  = parity12(ord_nxt, vel_select_i & velocity_neg_i);
    drv_now  = {encoder_channel_a_out_i, encoder_channel_b_out_i,
                encoder_index_out_i, alarm_drive_i};
    dmis_nxt = (drv_now != enc_mon) | ~ord_mon | ~prd_mon;
    iof_nxt  = iof_r | (alarm_drive_i != pads_s2_r[2]);
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cs_s_r    <= 2'h3;
      sck_s_r   <= 2'h0;
      sdi_s_r   <= 2'h0;
      sck_d_r   <= 1'b0;
      pads_s1_r <= 6'h00;
      pads_s2_r <= 6'h00;
      ordp_s1_r <= 13'h0000;
      ordp_s2_r <= 13'h0000;
      rx_r      <= 32'h00000000;
      tx_r      <= 32'h00000000;
      cnt_r     <= 6'h00;
      crc_r     <= rspi_pkg::CRC_SEED;
      busy_r    <= 1'b0;
      sdo_r     <= 1'b0;
      oe_r      <= 1'b0;
      echo_r    <= 8'h00;
      rdata_r   <= 16'h0000;
      stat_r    <= 2'h0;
      spierr_r  <= 1'b0;
      ctl1_r    <= 16'h0000;
      ctl2_r    <= 16'h0000;
      eectl_r   <= 16'h0000;
      dcfg_r    <= 16'h0000;
      load_r    <= 1'b0;
      ord_r     <= 12'h000;
      prd_r     <= 1'b0;
      iof_r     <= 1'b0;
      dmis_r    <= 1'b0;
    end
    else
    begin
      cs_s_r    <= cs_s_nxt;
      sck_s_r   <= sck_s_nxt;
      sdi_s_r   <= sdi_s_nxt;
      sck_d_r   <= sck_d_nxt;
      pads_s1_r <= pads_s1_nxt;
      pads_s2_r <= pads_s2_nxt;
      ordp_s1_r <= ordp_s1_nxt;
      ordp_s2_r <= ordp_s2_nxt;
      rx_r      <= rx_nxt;
      tx_r      <= tx_nxt;
      cnt_r     <= cnt_nxt;
      crc_r     <= crc_nxt;
      busy_r    <= busy_nxt;
      sdo_r     <= sdo_nxt;
      oe_r      <= oe_nxt;
      echo_r    <= echo_nxt;
      rdata_r   <= rdata_nxt;
      stat_r    <= stat_nxt;
      spierr_r  <= spierr_nxt;
      ctl1_r    <= ctl1_nxt;
      ctl2_r    <= ctl2_nxt;
      eectl_r   <= eectl_nxt;
      dcfg_r    <= dcfg_nxt;
      load_r    <= load_nxt;
      ord_r     <= ord_nxt;
      prd_r     <= prd_nxt;
      iof_r     <= iof_nxt;
      dmis_r    <= dmis_nxt;
    end
  end

  // unlock flags registered for outputs
  logic cu_r, eu_r;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cu_r <= 1'b0;
      eu_r <= 1'b0;
    end
    else
    begin
      cu_r <= ctrl_open;
      eu_r <= ee_open;
    end
  end

  assign sdo_o                       = sdo_r;
  assign sdo_oe_o                    = oe_r;
  assign angle_velocity_out_bits_o   = ord_r;
  assign output_parity_bit_o         = prd_r;
  assign output_pin_mismatch_error_o = iof_r;
  assign protected_control_one_o     = ctl1_r;
  assign protected_control_two_o     = ctl2_r;
  assign eeprom_control_register_o   = eectl_r;
  assign diag_config_o               = dcfg_r;
  assign ctrl_unlocked_o             = cu_r;
  assign ee_unlocked_o               = eu_r;
endmodule // rspi_slave
`default_nettype wire

// ---- hdl/rspi_pkg.sv ----
package rspi_pkg;
  localparam int unsigned FRAME_BITS    = 32;
  localparam int unsigned HDR_BITS      = 24;
  localparam int unsigned CRC_BITS      = 6;
  localparam logic [5:0]  CRC_SEED      = 6'h3F;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned UNLOCK_MS     = 10;
  localparam int unsigned UNLOCK_CYC    = CLK_HZ / 1000 * UNLOCK_MS;
  // response status codes
  localparam logic [1:0]  ST_OK         = 2'h0;
  localparam logic [1:0]  ST_CRC        = 2'h1;
  localparam logic [1:0]  ST_MISMATCH   = 2'h2;
  localparam logic [1:0]  ST_ADDR       = 2'h3;
  // unlock keys
  localparam logic [15:0] KEY_0         = 16'h000F;
  localparam logic [15:0] KEY_1         = 16'h0055;
  localparam logic [15:0] KEY_2         = 16'h00AA;
  localparam logic [15:0] KEY_3         = 16'h00F0;
  // read addresses
  localparam logic [7:0]  RD_CTRL1      = 8'h90;
  localparam logic [7:0]  RD_CTRL2      = 8'h63;
  localparam logic [7:0]  RD_STAT1      = 8'h81;
  localparam logic [7:0]  RD_STAT2      = 8'h4D;
  localparam logic [7:0]  RD_STAT4      = 8'h1F;
  localparam logic [7:0]  RD_STAT5      = 8'h41;
  localparam logic [7:0]  RD_STAT6      = 8'h6F;
  localparam logic [7:0]  RD_EECTL      = 8'hE3;
  localparam logic [7:0]  RD_EEUNLK     = 8'hBA;
  localparam logic [7:0]  RD_UNLK       = 8'h64;
  localparam logic [7:0]  RD_DIAGCFG    = 8'hA6;
  // write addresses
  localparam logic [7:0]  WR_CTRL1      = 8'h0D;
  localparam logic [7:0]  WR_CTRL2      = 8'h38;
  localparam logic [7:0]  WR_EECTL      = 8'h6E;
  localparam logic [7:0]  WR_EEUNLK     = 8'h56;
  localparam logic [7:0]  WR_UNLK       = 8'h95;
  localparam logic [7:0]  WR_DIAGCFG    = 8'h42;
  // data field bit positions
  localparam int unsigned STAT4_SPIERR  = 0;
  localparam int unsigned PRD_POS       = 12;
  localparam int unsigned SIGN_POS      = 13;
endpackage

// ---- hdl/rspi_unlock.sv ----
`timescale 1ns/1ns
`default_nettype none
module rspi_unlock #(
  parameter int unsigned WINDOW_CYC = rspi_pkg::UNLOCK_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // write strobe with data
  input  wire logic        wr_i,
  input  wire logic [15:0] data_i,
  // result
  output logic             unlocked_o
);
  logic [1:0]  step_r,  step_nxt;
  logic [31:0] tmr_r,   tmr_nxt;
  logic        unl_r,   unl_nxt;

  always_comb
  begin
    step_nxt = step_r;
    tmr_nxt  = tmr_r;
    unl_nxt  = unl_r;
    if (step_r != 2'h0)
    begin
      tmr_nxt = tmr_r + 32'h1;
    end
    if (step_r != 2'h0 && tmr_r >= WINDOW_CYC)
    begin
      step_nxt = 2'h0;
    end
    if (wr_i)
    begin
      unique case (step_r)
        2'h0: step_nxt = (data_i == rspi_pkg::KEY_0) ? 2'h1 : 2'h0;
        2'h1: step_nxt = (data_i == rspi_pkg::KEY_1) ? 2'h2 : 2'h0;
        2'h2: step_nxt = (data_i == rspi_pkg::KEY_2) ? 2'h3 : 2'h0;
        2'h3: step_nxt = 2'h0;
      endcase
      if (step_r == 2'h0)
      begin
        tmr_nxt = 32'h0;
      end
      if (step_r == 2'h3 && data_i == rspi_pkg::KEY_3 && tmr_r < WINDOW_CYC)
      begin
        unl_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      step_r <= 2'h0;
      tmr_r  <= 32'h0;
      unl_r  <= 1'b0;
    end
    else
    begin
      step_r <= step_nxt;
      tmr_r  <= tmr_nxt;
      unl_r  <= unl_nxt;
    end
  end

  assign unlocked_o = unl_r;
endmodule // rspi_unlock
`default_nettype wire

// ---- test/rspi_slave_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module rspi_slave_assertions #(
  parameter int unsigned UNLOCK_CYC = rspi_pkg::UNLOCK_CYC
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  // watched inputs
  input wire logic        chip_select_n_i,
  input wire logic [11:0] angle_i,
  input wire logic [11:0] velocity_i,
  input wire logic        velocity_neg_i,
  input wire logic        vel_select_i,
  input wire logic        diag_state_i,
  input wire logic        alarm_drive_i,
  input wire logic        pad_alarm_i,
  // watched outputs
  input wire logic        sdo_oe_o,
  input wire logic [11:0] angle_velocity_out_bits_o,
  input wire logic        output_parity_bit_o,
  input wire logic        output_pin_mismatch_error_o,
  input wire logic [15:0] protected_control_one_o,
  input wire logic [15:0] protected_control_two_o,
  input wire logic [15:0] eeprom_control_register_o,
  input wire logic [15:0] diag_config_o,
  input wire logic        ctrl_unlocked_o,
  input wire logic        ee_unlocked_o
);
  logic [3:0] al_age_r;
  logic [3:0] al_age_nxt;

  // cycles since the alarm pad last disagreed with its drive
  always_comb
  begin
    al_age_nxt = al_age_r;
    if (pad_alarm_i != alarm_drive_i)
      al_age_nxt = 4'h0;
    else if (al_age_r != 4'hF)
      al_age_nxt = al_age_r + 4'h1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      al_age_r <= 4'hF;
    else
      al_age_r <= al_age_nxt;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_oe_idle: assert property (chip_select_n_i[*5] |-> !sdo_oe_o)
    else $error("data out driven while deselected");
  a_oe_frame: assert property (!chip_select_n_i[*5] |-> sdo_oe_o)
    else $error("data out not driven while selected");
  a_par_equation: assert property (($stable({angle_i, velocity_i, velocity_neg_i, vel_select_i})
    && arst_n_i)[*3] |-> output_parity_bit_o == (^angle_velocity_out_bits_o
    ^ (vel_select_i & velocity_neg_i)))
    else $error("parity pin wrong");
  a_data_select: assert property (($stable({angle_i, velocity_i, vel_select_i}))[*2]
    |-> angle_velocity_out_bits_o == (vel_select_i ? velocity_i : angle_i))
    else $error("parallel data wrong");
  a_ctrl_guard: assert property (!$stable({protected_control_one_o, protected_control_two_o})
    |-> ctrl_unlocked_o)
    else $error("control register changed while locked");
  a_ee_guard: assert property (!$stable(eeprom_control_register_o) |-> ee_unlocked_o)
    else $error("eeprom control changed while locked");
  a_diag_guard: assert property (!$stable(diag_config_o) |-> diag_state_i)
    else $error("diag config written in normal state");
  a_unlock_held: assert property (!($fell(ctrl_unlocked_o) || $fell(ee_unlocked_o)))
    else $error("unlock dropped without reset");
  a_unlock_idle: assert property ($rose(ctrl_unlocked_o) || $rose(ee_unlocked_o)
    |-> chip_select_n_i)
    else $error("unlock opened inside a frame");
  a_alarm_cause: assert property ($rose(output_pin_mismatch_error_o) |-> al_age_r < 4'h8)
    else $error("output fault without alarm pin mismatch");
  a_alarm_raise: assert property ((pad_alarm_i != alarm_drive_i)[*6]
    |-> ##[0:2] output_pin_mismatch_error_o)
    else $error("alarm pin mismatch not flagged");
endmodule // rspi_slave_assertions
`default_nettype wire

// ---- test/rspi_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module rspi_host_model (
  // spi pins toward the slave
  output var logic cs_n_o,
  output var logic sclk_o,
  output var logic sdi_o,
  // slave data line
  input  wire logic miso_i
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end

  // serial crc-6 from the top bit, seed all ones
  function automatic logic [5:0] crc6(input logic [23:0] d);
    logic [5:0] c;
    logic       v;
    c = 6'h3F;
    for (int i = 23; i >= 0; i--)
    begin
      v = c[5] ^ d[i];
      c = {c[4], c[3] ^ v, c[2] ^ v, c[1], c[0] ^ v, v};
    end
    return c;
  endfunction

  // one select period of n clocks, msb first, clock still outside it
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    cs_n_o = 1'b0;
    #320;
    for (int i = 0; i < n; i++)
    begin
      sdi_o = tx[31 - (i % 32)];
      #160;
      sclk_o = 1'b1;
      #150;
      rx = {rx[30:0], miso_i};
      #10;
      sclk_o = 1'b0;
    end
    #160;
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // released line loses its last bit
    #400; // select high gap
  endtask
endmodule // rspi_host_model
`default_nettype wire

// ---- test/test_rspi_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_rspi_slave;
  logic             clk_i = 1'b0;
  logic             arst_n_i = 1'b0;
  logic [11:0]      ang = 12'h000;
  logic [11:0]      vel = 12'h000;
  logic             neg = 1'b0;
  logic             vsel = 1'b0;
  logic             diag = 1'b0;
  logic             enc = 1'b0;
  logic             al = 1'b0;
  logic             bad_a = 1'b0;
  logic             bad_al = 1'b0;
  logic [31:0]      rx;
  int               errors = 0;
  int               comparisons = 0;
  wire logic        cs_n, sclk, sdi, sdo, oe, output_parity_bit, err, cu, eu;
  wire logic [11:0] angle_velocity_out_bits;
  wire logic [15:0] c1, c2, ee, dc;
  wire logic        miso = oe ? sdo : 1'bz;

  initial forever #20 clk_i = ~clk_i;

  rspi_slave #(.UNLOCK_CYC(2000)) rspi_slave_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .chip_select_n_i(cs_n), .sclk_i(sclk),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(oe), .angle_i(ang), .velocity_i(vel),
    .velocity_neg_i(neg), .vel_select_i(vsel), .diag_state_i(diag),
    .encoder_channel_a_out_i(enc), .encoder_channel_b_out_i(enc),
    .encoder_index_out_i(enc), .alarm_drive_i(al), .pad_a_i(enc ^ bad_a),
    .pad_b_i(enc), .pad_z_i(enc), .pad_alarm_i(al ^ bad_al), .pad_ord_i(angle_velocity_out_bits),
    .pad_prd_i(output_parity_bit), .angle_velocity_out_bits_o(angle_velocity_out_bits), .output_parity_bit_o(output_parity_bit),
    .output_pin_mismatch_error_o(err), .protected_control_one_o(c1),
    .protected_control_two_o(c2), .eeprom_control_register_o(ee),
    .diag_config_o(dc), .ctrl_unlocked_o(cu), .ee_unlocked_o(eu));

  rspi_host_model rspi_host_model_i (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .miso_i(miso));

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, s, e);
    end
  endtask

  task automatic gap(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic xf(input logic [7:0] a, input logic [15:0] d, input int n = 32,
                    input logic [5:0] x = 6'h00);
    rspi_host_model_i.xfer({a, d, 2'h0, rspi_host_model_i.crc6({a, d}) ^ x}, n, rx);
  endtask

  task automatic rep(input logic [7:0] a, input logic [1:0] st);
    chk(rx[31:24], a);
    chk(rx[7:6], st);
    chk(rx[5:0], rspi_host_model_i.crc6(rx[31:8]));
  endtask

  // angle, then negative velocity
  task automatic t_data;
    ang = 12'hA5C;
    gap(5);
    xf(rspi_pkg::RD_STAT5, 16'h0000);
    vsel = 1'b1;
    neg = 1'b1;
    vel = 12'h3C1;
    gap(5);
    xf(rspi_pkg::RD_STAT6, 16'h0000);
    rep(rspi_pkg::RD_STAT5, rspi_pkg::ST_OK);
    chk(rx[23:8], {3'h0, ^ang, ang});
    xf(rspi_pkg::RD_STAT2, 16'h0000);
    rep(rspi_pkg::RD_STAT6, rspi_pkg::ST_OK);
    chk(rx[23:8], {2'h0, 1'b1, ~^vel, vel});
    chk({output_parity_bit, angle_velocity_out_bits}, {~^vel, vel});
  endtask

  // crc fault, clock count faults, error flag read order
  task automatic t_crc;
    xf(rspi_pkg::RD_STAT4, 16'h0000, 32, 6'h01);
    chk(rx[9:8], 2'h3);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    chk(rx[7:6], rspi_pkg::ST_CRC);
    xf(rspi_pkg::RD_STAT1, 16'h0000);
    rep(rspi_pkg::RD_STAT4, rspi_pkg::ST_OK);
    chk(rx[8], 1'b1);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    chk(rx[8], 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      xf(rspi_pkg::RD_STAT4, 16'h0000, 31 + 2 * i);
      xf(rspi_pkg::RD_STAT4, 16'h0000);
      chk(rx[7:6], rspi_pkg::ST_CRC);
    end
  endtask

  // coinciding faults, non-alarm pad mismatch
  task automatic t_prio;
    bad_a = 1'b1;
    gap(5);
    xf(8'h00, 16'h0000);
    xf(rspi_pkg::RD_STAT4, 16'h0000, 32, 6'h01);
    chk(rx[7:6], rspi_pkg::ST_MISMATCH);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    chk(rx[7:6], rspi_pkg::ST_CRC);
    chk(err, 1'b0);
    bad_a = 1'b0;
    gap(5);
    xf(8'h00, 16'h0000);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    chk(rx[7:6], rspi_pkg::ST_ADDR);
  endtask

  // diagnostics-only write in both states
  task automatic t_diag;
    xf(rspi_pkg::WR_DIAGCFG, 16'h0F0F);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    chk({rx[7:6], dc}, {rspi_pkg::ST_ADDR, 16'h0000});
    diag = 1'b1;
    gap(5);
    xf(rspi_pkg::WR_DIAGCFG, 16'h0F0F);
    xf(rspi_pkg::RD_DIAGCFG, 16'h0000);
    rep(rspi_pkg::WR_DIAGCFG, rspi_pkg::ST_OK);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    chk({rx[23:8], dc}, {16'h0F0F, 16'h0F0F});
  endtask

  // locked write, key sequences, a sequence that runs too long
  task automatic t_unlock;
    logic [15:0] k [4];
    k = '{rspi_pkg::KEY_0, rspi_pkg::KEY_1, rspi_pkg::KEY_2, rspi_pkg::KEY_3};
    xf(rspi_pkg::WR_CTRL1, 16'h1234);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    chk({rx[7:6], c1}, {rspi_pkg::ST_ADDR, 16'h0000});
    for (int i = 0; i < 4; i++)
      xf(rspi_pkg::WR_UNLK, k[i]);
    xf(rspi_pkg::WR_CTRL1, 16'h1234);
    xf(rspi_pkg::WR_CTRL2, 16'h5A5A);
    rep(rspi_pkg::WR_CTRL1, rspi_pkg::ST_OK);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    chk({c1, c2}, {16'h1234, 16'h5A5A});
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        gap(2100);
      xf(rspi_pkg::WR_EEUNLK, k[i]);
    end
    xf(rspi_pkg::WR_EECTL, 16'hC3C3);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    chk({rx[7:6], eu}, {rspi_pkg::ST_ADDR, 1'b0});
    for (int i = 0; i < 4; i++)
      xf(rspi_pkg::WR_EEUNLK, k[i]);
    xf(rspi_pkg::WR_EECTL, 16'hC3C3);
    xf(rspi_pkg::RD_STAT4, 16'h0000);
    chk({rx[7:6], eu, ee}, {rspi_pkg::ST_OK, 1'b1, 16'hC3C3});
  endtask

  // alarm pin mismatch, then a second reset
  task automatic t_alarm;
    int n;
    bad_al = 1'b1;
    n = 0;
    while (err !== 1'b1 && n < 20)
    begin
      gap(1);
      n++;
    end
    chk(err, 1'b1);
    if (n == 20)
      end_of_test();
    bad_al = 1'b0;
    gap(10);
    chk({err, cu, eu}, 3'h7);
    arst_n_i = 1'b0;
    gap(2);
    chk({err, cu, eu, oe}, 4'h0);
    arst_n_i = 1'b1;
    gap(4);
  endtask

  initial
  begin
    #3000000;
    errors++;
    end_of_test();
  end

  initial
  begin
    repeat (20) @(negedge clk_i);
    arst_n_i = 1'b1;
    gap(4);
    chk({oe, err, cu, eu, c1}, 20'h00000);
    t_data();
    t_crc();
    t_prio();
    t_diag();
    t_unlock();
    t_alarm();
    end_of_test();
  end
endmodule // test_rspi_slave

bind rspi_slave rspi_slave_assertions #(.UNLOCK_CYC(UNLOCK_CYC)) rspi_slave_assertions_i (.*);
`default_nettype wire
